// ### verilog/gpc_defines.svh
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH

// avalon byte addresses of the access window
`define GPC_ADDR_CTRL    8'h00
`define GPC_ADDR_INDEX   8'h04
`define GPC_ADDR_DATA    8'h08
`define GPC_ADDR_PINS    8'h0c

// control register fields
`define GPC_CTRL_CFG     0
`define GPC_CTRL_PMEOD   1

// index values of the configuration registers
`define GPC_IDX_POL2     8'h34
`define GPC_IDX_DIR3     8'h35
`define GPC_IDX_POL3     8'h36

// fields of the group2 polarity and alternate select register
`define GPC_POL2_PME     5
`define GPC_POL2_ALT3    6
`define GPC_POL2_ALT4    7

// reset values
`define GPC_RST_POL2     8'h00
`define GPC_RST_DIR3     8'h00
`define GPC_RST_POL3     8'h00
`define GPC_RST_INDEX    8'h00

`endif

// ### verilog/gpc_pkg.sv
package gpc_pkg;
    typedef logic [7:0] gpc_byte_t;
    typedef enum logic {GPC_IDLE, GPC_ACK} gpc_bus_e;
endpackage

// ### verilog/gpc_gpio_cfg.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "gpc_defines.svh"

module gpc_gpio_cfg
    import gpc_pkg::*;
#(
    parameter int G2W = 5,
    parameter int G3W = 8
) (
    input  wire logic           mclk,             // 250 MHz clock
    input  wire logic           reset,            // synchronous, active high
    input  wire logic [7:0]     avs_address,      // byte address
    input  wire logic           avs_read,         // read request
    input  wire logic           avs_write,        // write request
    input  wire logic [31:0]    avs_writedata,    // write data
    output logic      [31:0]    avs_readdata,     // read data
    output logic                avs_waitrequest,  // stall
    input  wire logic [G2W-1:0] g2DataOut,        // core data for second group pins
    input  wire logic [G2W-1:0] g2PinIn,          // second group pin levels
    output logic      [G2W-1:0] g2PinOut,         // second group pin drive
    output logic      [G2W-1:0] g2In,             // second group sampled data
    input  wire logic [G3W-1:0] g3DataOut,        // core data for third group pins
    input  wire logic [G3W-1:0] g3PinIn,          // third group pin levels
    output logic      [G3W-1:0] g3PinOut,         // third group pin drive
    output logic      [G3W-1:0] g3PinOeN,         // third group enable, low drives
    output logic      [G3W-1:0] g3In,             // third group sampled data
    input  wire logic           pmeReq,           // power event request, high
    output logic                pmeOut,           // power event pin level
    output logic                pmeOeN,           // power event enable, low drives
    input  wire logic           g1Pin3In,         // first group pin three level
    input  wire logic           g1Pin4In,         // first group pin four level
    output logic                g1Pin3Gpio,       // pin three as gpio input
    output logic                g1Pin4Gpio,       // pin four as gpio input
    output logic                extIrqIn1,        // external interrupt input one
    output logic                extIrqIn2         // external interrupt input two
);
    localparam int SW = G2W + G3W + 2;

    // bus slave state
    gpc_bus_e    st_q, st_d;
    logic [31:0] rdData_q, rdData_d;
    logic        wait_q, wait_d;
    logic        cfg_q, cfg_d;
    logic        pmeOd_q, pmeOd_d;
    gpc_byte_t   index_q, index_d;
    gpc_byte_t   pol2_q, pol2_d;
    gpc_byte_t   dir3_q, dir3_d;
    gpc_byte_t   pol3_q, pol3_d;
    logic        req;
    logic        wrEn;
    logic        idxHit;
    gpc_byte_t   cfgRead;

    assign req  = avs_read | avs_write;
    assign wrEn = (st_q == GPC_ACK) && avs_write;
    assign idxHit = (index_q == `GPC_IDX_POL2) || (index_q == `GPC_IDX_DIR3) || (index_q == `GPC_IDX_POL3);

    always_comb begin
        unique case (index_q)
            `GPC_IDX_POL2: cfgRead = pol2_q;
            `GPC_IDX_DIR3: cfgRead = dir3_q;
            `GPC_IDX_POL3: cfgRead = pol3_q;
            default:       cfgRead = 8'h00;
        endcase
    end

    always_comb begin
        st_d     = st_q;
        rdData_d = rdData_q;
        wait_d   = 1'b1;
        cfg_d    = cfg_q;
        pmeOd_d  = pmeOd_q;
        index_d  = index_q;
        pol2_d   = pol2_q;
        dir3_d   = dir3_q;
        pol3_d   = pol3_q;
        unique case (st_q)
            GPC_IDLE: begin
                if (req) begin
                    st_d     = GPC_ACK;
                    wait_d   = 1'b0;
                    rdData_d = 32'h0000_0000;
                    if (avs_read) begin
                        unique case (avs_address)
                            `GPC_ADDR_CTRL:  rdData_d = {30'h0, pmeOd_q, cfg_q};
                            `GPC_ADDR_INDEX: rdData_d = {24'h0, cfg_q ? index_q : 8'h00};
                            `GPC_ADDR_DATA:  rdData_d = {24'h0, (cfg_q && idxHit) ? cfgRead : 8'h00};
                            `GPC_ADDR_PINS:  rdData_d = {24'h0, g3In};
                            default:         rdData_d = 32'h0000_0000;
                        endcase
                    end
                end
            end
            GPC_ACK: begin
                st_d = GPC_IDLE;
                if (wrEn) begin
                    unique case (avs_address)
                        `GPC_ADDR_CTRL: begin
                            cfg_d   = avs_writedata[`GPC_CTRL_CFG];
                            pmeOd_d = avs_writedata[`GPC_CTRL_PMEOD];
                        end
                        `GPC_ADDR_INDEX: begin
                            if (cfg_q) begin
                                index_d = avs_writedata[7:0];
                            end
                        end
                        `GPC_ADDR_DATA: begin
                            if (cfg_q) begin
                                unique case (index_q)
                                    `GPC_IDX_POL2: pol2_d = avs_writedata[7:0];
                                    `GPC_IDX_DIR3: dir3_d = avs_writedata[7:0];
                                    `GPC_IDX_POL3: pol3_d = avs_writedata[7:0];
                                    default: ;
                                endcase
                            end
                        end
                        default: ;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q     <= GPC_IDLE;
            rdData_q <= 32'h0000_0000;
            wait_q   <= 1'b1;
            cfg_q    <= 1'b0;
            pmeOd_q  <= 1'b0;
            index_q  <= `GPC_RST_INDEX;
            pol2_q   <= `GPC_RST_POL2;
            dir3_q   <= `GPC_RST_DIR3;
            pol3_q   <= `GPC_RST_POL3;
        end else begin
            st_q     <= st_d;
            rdData_q <= rdData_d;
            wait_q   <= wait_d;
            cfg_q    <= cfg_d;
            pmeOd_q  <= pmeOd_d;
            index_q  <= index_d;
            pol2_q   <= pol2_d;
            dir3_q   <= dir3_d;
            pol3_q   <= pol3_d;
        end
    end

    assign avs_readdata    = rdData_q;
    assign avs_waitrequest = wait_q;

    // input synchroniser, three stages, change taken when last two agree
    logic [SW-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
    logic [SW-1:0] agree;

    assign agree = ~(s2_q ^ s3_q);

    always_comb begin
        filt_d = (agree & s3_q) | (~agree & filt_q);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            filt_q <= '0;
        end else begin
            s1_q   <= {g1Pin4In, g1Pin3In, g3PinIn, g2PinIn};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    logic [G2W-1:0] g2Filt;
    logic [G3W-1:0] g3Filt;
    logic           g1P3Filt, g1P4Filt;

    assign g2Filt   = filt_q[G2W-1:0];
    assign g3Filt   = filt_q[G2W+G3W-1:G2W];
    assign g1P3Filt = filt_q[SW-2];
    assign g1P4Filt = filt_q[SW-1];

    // pin side outputs
    logic [G2W-1:0] g2PinOut_q, g2PinOut_d, g2In_q, g2In_d;
    logic [G3W-1:0] g3PinOut_q, g3PinOut_d, g3Oe_q, g3Oe_d, g3In_q, g3In_d;
    logic           pmeOut_q, pmeOut_d, pmeOe_q, pmeOe_d, pmeLevel;
    logic           g1P3_q, g1P3_d, g1P4_q, g1P4_d, irq1_q, irq1_d, irq2_q, irq2_d;

    // non-inverted gives an active low pin: asserted request drives 0
    assign pmeLevel = ~pmeReq ^ pol2_q[`GPC_POL2_PME];

    genvar gi;
    generate
        for (gi = 0; gi < G3W; gi++) begin : g_grp3
            always_comb begin
                g3PinOut_d[gi] = g3DataOut[gi] ^ pol3_q[gi];
                g3Oe_d[gi]     = ~dir3_q[gi];
                g3In_d[gi]     = g3Filt[gi] ^ pol3_q[gi];
            end
        end
    endgenerate

    always_comb begin
        g2PinOut_d = g2DataOut ^ pol2_q[G2W-1:0];
        g2In_d     = g2Filt ^ pol2_q[G2W-1:0];
        pmeOut_d   = pmeLevel;
        pmeOe_d    = pmeOd_q & pmeLevel;
        irq1_d     = pol2_q[`GPC_POL2_ALT3] & g1P3Filt;
        irq2_d     = pol2_q[`GPC_POL2_ALT4] & g1P4Filt;
        g1P3_d     = ~pol2_q[`GPC_POL2_ALT3] & g1P3Filt;
        g1P4_d     = ~pol2_q[`GPC_POL2_ALT4] & g1P4Filt;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            g2PinOut_q <= '0;
            g2In_q     <= '0;
            g3PinOut_q <= '0;
            g3Oe_q     <= '1;
            g3In_q     <= '0;
            pmeOut_q   <= 1'b1;
            pmeOe_q    <= 1'b1;
            irq1_q     <= 1'b0;
            irq2_q     <= 1'b0;
            g1P3_q     <= 1'b0;
            g1P4_q     <= 1'b0;
        end else begin
            g2PinOut_q <= g2PinOut_d;
            g2In_q     <= g2In_d;
            g3PinOut_q <= g3PinOut_d;
            g3Oe_q     <= g3Oe_d;
            g3In_q     <= g3In_d;
            pmeOut_q   <= pmeOut_d;
            pmeOe_q    <= pmeOe_d;
            irq1_q     <= irq1_d;
            irq2_q     <= irq2_d;
            g1P3_q     <= g1P3_d;
            g1P4_q     <= g1P4_d;
        end
    end

    assign g2PinOut   = g2PinOut_q;
    assign g2In       = g2In_q;
    assign g3PinOut   = g3PinOut_q;
    assign g3PinOeN   = g3Oe_q;
    assign g3In       = g3In_q;
    assign pmeOut     = pmeOut_q;
    assign pmeOeN     = pmeOe_q;
    assign extIrqIn1  = irq1_q;
    assign extIrqIn2  = irq2_q;
    assign g1Pin3Gpio = g1P3_q;
    assign g1Pin4Gpio = g1P4_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_data_gated: assert property ((st_q == GPC_ACK) && avs_write && !cfg_q |=>
        $stable(pol2_q) && $stable(dir3_q) && $stable(pol3_q))
        else $error("config register changed outside configuration state");

    a_read_gated: assert property ((st_q == GPC_IDLE) && avs_read && (avs_address == `GPC_ADDR_DATA)
        && !cfg_q |=> !avs_waitrequest && (avs_readdata == 32'h0))
        else $error("data read outside configuration state not zero");

    a_pol2_drive: assert property (!$past(reset) |-> g2PinOut == $past(g2DataOut ^ pol2_q[G2W-1:0]))
        else $error("second group drive polarity wrong");

    a_pme_lowact: assert property (!reset && !pol2_q[`GPC_POL2_PME] && pmeReq ##1 $stable(pol2_q)
        |-> !pmeOut)
        else $error("non-inverted power event not active low");

    a_pme_invert: assert property (!reset && pol2_q[`GPC_POL2_PME] && pmeReq |=> pmeOut)
        else $error("inverted power event level wrong");

    a_pme_buffer: assert property (!$past(reset) |-> (pmeOeN == ($past(pmeOd_q) & pmeOut)))
        else $error("power event buffer type wrong");

    a_irq_route: assert property (!$past(reset) |-> (extIrqIn1 == ($past(pol2_q[`GPC_POL2_ALT3]) & $past(g1P3Filt)))
        && (g1Pin4Gpio == (!$past(pol2_q[`GPC_POL2_ALT4]) & $past(g1P4Filt))))
        else $error("interrupt input routing wrong");

    a_dir3_enable: assert property (!$past(reset) |-> g3PinOeN == ~$past(dir3_q))
        else $error("third group direction wrong");

    a_pol3_sample: assert property (!$past(reset) |-> g3In == $past(g3Filt ^ pol3_q))
        else $error("third group sampled polarity wrong");

    a_reset_clear: assert property ($past(reset) |-> (dir3_q == 8'h00) && (pol3_q == 8'h00))
        else $error("third group registers not cleared by reset");

    a_bus_answer: assert property ((st_q == GPC_IDLE) && (avs_read || avs_write) ##1 1'b1
        |-> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");
endmodule

// ### verif/gpc_pin_model.sv
`timescale 1ns/1ps
module gpc_pin_model (
    input  wire logic [7:0] g3PinOut,  // block drive level
    input  wire logic [7:0] g3PinOeN,  // low where the block drives
    input  wire logic [7:0] extLevel,  // board level on released pins
    output logic      [7:0] g3PinIn    // resolved pin level
);
    // driven pins read back the block level, released pins the board level
    // board never drives a pin that software set as output
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            g3PinIn[i] = g3PinOeN[i] ? extLevel[i] : g3PinOut[i];
        end
    end
endmodule

// ### verif/test_gpc_gpio_cfg.sv
`timescale 1ns/1ps
`include "gpc_defines.svh"
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin errCount++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module test_gpc_gpio_cfg;
    import gpc_pkg::*;
    logic mclk, reset, avs_read, avs_write, avs_waitrequest, pmeReq, pmeOut, pmeOeN;
    logic g1Pin3In, g1Pin4In, g1Pin3Gpio, g1Pin4Gpio, extIrqIn1, extIrqIn2;
    logic [7:0] avs_address, g3DataOut, g3PinIn, g3PinOut, g3PinOeN, g3In, extLevel;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [4:0] g2DataOut, g2PinIn, g2PinOut, g2In;
    int errCount, samplesChecked, seed;
    logic [1:0] ctrl;
    gpc_byte_t idx, regs [3];

    gpc_gpio_cfg u_dut (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .g2DataOut(g2DataOut), .g2PinIn(g2PinIn), .g2PinOut(g2PinOut),
        .g2In(g2In), .g3DataOut(g3DataOut), .g3PinIn(g3PinIn), .g3PinOut(g3PinOut), .g3PinOeN(g3PinOeN),
        .g3In(g3In), .pmeReq(pmeReq), .pmeOut(pmeOut), .pmeOeN(pmeOeN), .g1Pin3In(g1Pin3In),
        .g1Pin4In(g1Pin4In), .g1Pin3Gpio(g1Pin3Gpio), .g1Pin4Gpio(g1Pin4Gpio), .extIrqIn1(extIrqIn1),
        .extIrqIn2(extIrqIn2));
    gpc_pin_model u_pins (.g3PinOut(g3PinOut), .g3PinOeN(g3PinOeN), .extLevel(extLevel), .g3PinIn(g3PinIn));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic giveVerdict;
        $display("checks %0d errors %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    // model of the register window, updated only where a write is accepted
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        if (a == `GPC_ADDR_CTRL) ctrl = d[1:0];
        else if (a == `GPC_ADDR_INDEX && ctrl[0]) idx = d[7:0];
        else if (a == `GPC_ADDR_DATA && ctrl[0] && idx >= 8'h34 && idx <= 8'h36) regs[idx - 8'h34] = d[7:0];
    endtask

    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        e = '0;
        if (a == `GPC_ADDR_CTRL) e[1:0] = ctrl;
        else if (a == `GPC_ADDR_INDEX && ctrl[0]) e[7:0] = idx;
        else if (a == `GPC_ADDR_DATA && ctrl[0] && idx >= 8'h34 && idx <= 8'h36) e[7:0] = regs[idx - 8'h34];
        else if (a == `GPC_ADDR_PINS) e[7:0] = (regs[1] & g3DataOut) | (~regs[1] & (extLevel ^ regs[2]));
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask

    task automatic chkPins;
        g2DataOut <= 5'($random(seed));
        g2PinIn   <= 5'($random(seed));
        g3DataOut <= 8'($random(seed));
        extLevel  <= 8'($random(seed));
        pmeReq    <= 1'($random(seed));
        g1Pin3In  <= 1'($random(seed));
        g1Pin4In  <= 1'($random(seed));
        repeat (8) @(posedge mclk);
        `CHK(g2PinOut, g2DataOut ^ regs[0][4:0])
        `CHK(g2In, g2PinIn ^ regs[0][4:0])
        `CHK(pmeOut, ~pmeReq ^ regs[0][5])
        `CHK(pmeOeN, ctrl[1] & (~pmeReq ^ regs[0][5]))
        `CHK({extIrqIn2, extIrqIn1}, {g1Pin4In & regs[0][7], g1Pin3In & regs[0][6]})
        `CHK({g1Pin4Gpio, g1Pin3Gpio}, {g1Pin4In & ~regs[0][7], g1Pin3In & ~regs[0][6]})
        `CHK(g3PinOeN, ~regs[1])
        `CHK(g3PinOut, g3DataOut ^ regs[2])
        `CHK(g3In, (regs[1] & g3DataOut) | (~regs[1] & (extLevel ^ regs[2])))
        rd(`GPC_ADDR_PINS);
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        errCount++;
        giveVerdict();
    end

    initial begin
        seed = 32'hc2a52ec9;
        {reset, avs_read, avs_write, pmeReq, g1Pin3In, g1Pin4In} = 6'h20;
        {avs_address, avs_writedata, g2DataOut, g2PinIn, g3DataOut, extLevel} = '0;
        {ctrl, idx, regs[0], regs[1], regs[2]} = '0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chkPins();
        // outside configuration state the index and data registers are not reachable
        wr(`GPC_ADDR_INDEX, 32'h34);
        wr(`GPC_ADDR_DATA, 32'hff);
        rd(`GPC_ADDR_INDEX);
        rd(`GPC_ADDR_DATA);
        wr(`GPC_ADDR_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(`GPC_ADDR_INDEX, 32'(8'h34 + i));
            rd(`GPC_ADDR_DATA);
            wr(`GPC_ADDR_DATA, 32'hffffffff);
            rd(`GPC_ADDR_DATA);
        end
        rd(8'h10);
        for (int k = 0; k < 8; k++) begin
            wr(`GPC_ADDR_CTRL, {31'($random(seed)), 1'b1});
            for (int i = 0; i < 3; i++) begin
                wr(`GPC_ADDR_INDEX, 32'(8'h34 + i));
                wr(`GPC_ADDR_DATA, (k == 0) ? 32'h0 : $random(seed));
                rd(`GPC_ADDR_DATA);
                rd(`GPC_ADDR_CTRL);
            end
            chkPins();
        end
        // reset in mid-run clears every register again
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        {ctrl, idx, regs[0], regs[1], regs[2]} = '0;
        @(posedge mclk);
        wr(`GPC_ADDR_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(`GPC_ADDR_INDEX, 32'(8'h34 + i));
            rd(`GPC_ADDR_DATA);
        end
        chkPins();
        wr(`GPC_ADDR_CTRL, 32'h2);
        wr(`GPC_ADDR_DATA, 32'h5a);
        rd(`GPC_ADDR_DATA);
        chkPins();
        giveVerdict();
    end
endmodule
